/* File: rtl/xlate_pkg.sv */
package xlate_pkg;

  // Processor register numbers seen on the register-move port
  localparam logic [7:0] IPR_BASE_FIRST    = 8'h08;
  localparam logic [7:0] IPR_BASE_LAST     = 8'h0d;
  localparam logic [7:0] IPR_DIAG_TAG      = 8'h2f;
  localparam logic [7:0] IPR_MAP_ENABLE    = 8'h38;
  localparam logic [7:0] IPR_INVAL_ALL     = 8'h39;
  localparam logic [7:0] IPR_INVAL_ONE     = 8'h3a;
  localparam logic [7:0] IPR_DIAG_DATA     = 8'h3b;
  localparam logic [7:0] IPR_PROBE         = 8'h3f;

  // Field positions
  localparam int VA_VPN_HI       = 31;
  localparam int VA_VPN_LO       = 9;
  localparam int VPN_W           = VA_VPN_HI - VA_VPN_LO + 1;
  localparam int PTE_VALID_POS   = 31;
  localparam int PTE_PROTECTION_CODE_HI     = 30;
  localparam int PTE_PROTECTION_CODE_LO     = 27;
  localparam int PTE_MOD_POS     = 26;
  localparam int PTE_PFN_HI      = 20;
  localparam int PTE_PFN_LO      = 0;
  localparam int PFN_W           = PTE_PFN_HI - PTE_PFN_LO + 1;
  localparam int PROTECTION_CODE_W          = PTE_PROTECTION_CODE_HI - PTE_PROTECTION_CODE_LO + 1;
  localparam int MAP_ENABLE_BIT  = 0;
  localparam int PSL_OVF_BIT     = 1;

  // Reset values
  localparam logic MAP_ENABLE_RESET = 1'b0;

  // Stored page table entry part, 27 bits
  typedef struct packed {
    logic              page_entry_valid_bit;
    logic [PROTECTION_CODE_W-1:0] protection_code;
    logic              page_modified_bit;
    logic [PFN_W-1:0]  page_frame_number;
  } pte_part_t;

  // Registered lookup answer
  typedef struct packed {
    logic                  done;
    logic                  hit;
    logic                  miss;
    pte_part_t             page_table_entry;
    logic [PFN_W+8:0]      phys_addr;
  } lookup_result_t;

  // Register-move answer
  typedef struct packed {
    logic        rd_ack;
    logic [31:0] rd_data;
    logic        rsvd_fault;
    logic        probe_done;
    logic        psl_ovf_set;
  } ipr_result_t;

endpackage

/* File: rtl/translation_buffer_nlu.sv */
`timescale 1ns/1ps

// Operation
// - Sixty-four entries, any page in any entry, all searched at once.
// - No split between process-space and system-space entries.
// - Any write to the map enable register flushes the whole buffer.
// - Writes to page-table base or length registers 8 to 13 flush everything.
// - Invalidate-all flushes the buffer contents; invalidate-one clears only entries whose tag matches the page.
// - Entry is a 24-bit tag (page number plus valid) and 27-bit part.
// - Page part keeps frame number, valid, modified and protection code.
// - Address bits 31 to 9 are compared against every stored tag.
// - Hit only on tag match with valid set; that entry supplies translation.
// - No valid match gives a miss so the entry is fetched from memory.
// - A fetched entry is written where the replacement pointer points.
// - Pointer advances when the entry it selects is accessed.
// - Map enable is read-write; invalidate, diagnostic and probe are write-only.
// - Map enable is initialised by module reset.
// - Bit 0 of map enable only drives memory_map_enable_out; lookups translate either way; reads return the setting.
// - Probe write sets overflow code bit when the page is held valid.
// - Diagnostic tag loads page number, clears valid; data loads, validates, advances.
// - Reading invalidate, probe or diagnostic registers raises reserved operand fault.
module translation_buffer_nlu #(
  parameter int ENTRIES = 64
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       lookup_valid_in,
  input  wire logic [31:0]                lookup_va_in,
  input  wire logic                       fill_valid_in,
  input  wire logic [31:0]                fill_va_in,
  input  wire logic [31:0]                fill_pte_in,
  input  wire logic                       ipr_wr_in,
  input  wire logic                       ipr_rd_in,
  input  wire logic [7:0]                 ipr_num_in,
  input  wire logic [31:0]                ipr_wdata_in,
  output xlate_pkg::lookup_result_t       lookup_out,
  output xlate_pkg::ipr_result_t          ipr_out,
  output logic                            memory_map_enable_out
);

  localparam int PTR_W = $clog2(ENTRIES);

  // The pointer wraps by plain overflow, so the depth must be a power of two
  if (ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0) begin : g_bad_depth
    $error("ENTRIES must be a power of two of at least 2");
  end

  function automatic logic [PTR_W-1:0] first_index(input logic [ENTRIES-1:0] v);
    logic [PTR_W-1:0] idx;
    idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = PTR_W'(i);
      end
    end
    return idx;
  endfunction

  function automatic xlate_pkg::pte_part_t unpack_pte(input logic [31:0] raw);
    xlate_pkg::pte_part_t p;
    p.page_entry_valid_bit = raw[xlate_pkg::PTE_VALID_POS];
    p.protection_code      = raw[xlate_pkg::PTE_PROTECTION_CODE_HI:xlate_pkg::PTE_PROTECTION_CODE_LO];
    p.page_modified_bit    = raw[xlate_pkg::PTE_MOD_POS];
    p.page_frame_number    = raw[xlate_pkg::PTE_PFN_HI:xlate_pkg::PTE_PFN_LO];
    return p;
  endfunction

  function automatic logic [xlate_pkg::VPN_W-1:0] vpn_of(input logic [31:0] va);
    return va[xlate_pkg::VA_VPN_HI:xlate_pkg::VA_VPN_LO];
  endfunction

  logic [1:0]                        rst_sync_q;
  logic                              rst_n;
  logic [xlate_pkg::VPN_W-1:0]       tag_vpn_q [ENTRIES];
  xlate_pkg::pte_part_t              pte_q [ENTRIES];
  logic [ENTRIES-1:0]                entry_valid_flag_q;
  logic [ENTRIES-1:0]                entry_valid_flag_d;
  logic [PTR_W-1:0]                  not_last_used_pointer_q;
  logic [PTR_W-1:0]                  not_last_used_pointer_d;
  logic                              memory_map_enable_q;
  logic                              memory_map_enable_d;
  xlate_pkg::lookup_result_t         lookup_q;
  xlate_pkg::lookup_result_t         lookup_d;
  xlate_pkg::ipr_result_t            ipr_q;
  xlate_pkg::ipr_result_t            ipr_d;

  logic [ENTRIES-1:0]                look_match;
  logic [ENTRIES-1:0]                probe_match;
  logic [ENTRIES-1:0]                inval_match;

  // Release of reset through two flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Register-move decode
  wire wr_map_enable   = ipr_wr_in && (ipr_num_in == xlate_pkg::IPR_MAP_ENABLE);
  wire wr_base_length  = ipr_wr_in && (ipr_num_in >= xlate_pkg::IPR_BASE_FIRST)
                                   && (ipr_num_in <= xlate_pkg::IPR_BASE_LAST);
  wire xlate_invalidate_all = ipr_wr_in && (ipr_num_in == xlate_pkg::IPR_INVAL_ALL);
  wire xlate_invalidate_one = ipr_wr_in && (ipr_num_in == xlate_pkg::IPR_INVAL_ONE);
  wire xlate_diag_tag  = ipr_wr_in && (ipr_num_in == xlate_pkg::IPR_DIAG_TAG);
  wire xlate_diag_data = ipr_wr_in && (ipr_num_in == xlate_pkg::IPR_DIAG_DATA);
  wire xlate_probe     = ipr_wr_in && (ipr_num_in == xlate_pkg::IPR_PROBE);
  wire rd_map_enable   = ipr_rd_in && (ipr_num_in == xlate_pkg::IPR_MAP_ENABLE);
  wire rd_write_only   = ipr_rd_in && ((ipr_num_in == xlate_pkg::IPR_INVAL_ALL)
                                    || (ipr_num_in == xlate_pkg::IPR_INVAL_ONE)
                                    || (ipr_num_in == xlate_pkg::IPR_PROBE)
                                    || (ipr_num_in == xlate_pkg::IPR_DIAG_TAG)
                                    || (ipr_num_in == xlate_pkg::IPR_DIAG_DATA));
  wire flush_all       = wr_map_enable || wr_base_length || xlate_invalidate_all;

  // A fill loses to any register write that cycle; microcode keeps them apart
  wire fill_take       = fill_valid_in && !ipr_wr_in;

  // One comparator bank each for lookup, probe and invalidate-one; any entry may hold any page of either space
  for (genvar i = 0; i < ENTRIES; i++) begin : g_cmp
    assign look_match[i]  = entry_valid_flag_q[i]
                            && (tag_vpn_q[i] == vpn_of(lookup_va_in));
    assign probe_match[i] = entry_valid_flag_q[i]
                            && (tag_vpn_q[i] == vpn_of(ipr_wdata_in));
    assign inval_match[i] = tag_vpn_q[i] == vpn_of(ipr_wdata_in);
  end

  // A lookup racing a flush or single invalidate is answered as a miss
  wire                   look_any   = |look_match;
  wire                   look_hit   = lookup_valid_in && look_any
                                      && !flush_all && !xlate_invalidate_one;
  wire                   look_miss  = lookup_valid_in && !look_hit;
  wire [PTR_W-1:0]       look_idx   = first_index(look_match);
  wire                   look_at_ptr = look_hit && (look_idx == not_last_used_pointer_q);
  wire                   probe_hit  = xlate_probe && (|probe_match);
  wire xlate_pkg::pte_part_t hit_pte = pte_q[look_idx];
  wire [31:0]            map_rd_word = {31'h0000_0000, memory_map_enable_q};

  // Valid flags: flush wins, then writes at the pointer, then invalidate-one
  always_comb begin
    entry_valid_flag_d = entry_valid_flag_q;
    if (flush_all) begin
      entry_valid_flag_d = '0;
    end else begin
      if (xlate_invalidate_one) begin
        entry_valid_flag_d = entry_valid_flag_q & ~inval_match;
      end
      if (xlate_diag_tag) begin
        entry_valid_flag_d[not_last_used_pointer_q] = 1'b0;
      end
      if (xlate_diag_data || fill_take) begin
        entry_valid_flag_d[not_last_used_pointer_q] = 1'b1;
      end
    end
  end

  // Not-last-used pointer
  always_comb begin
    not_last_used_pointer_d = not_last_used_pointer_q;
    if (flush_all) begin
      not_last_used_pointer_d = '0;
    end else if (xlate_diag_data || fill_take || look_at_ptr) begin
      not_last_used_pointer_d = not_last_used_pointer_q + PTR_W'(1);
    end
  end

  always_comb begin
    memory_map_enable_d = memory_map_enable_q;
    if (wr_map_enable) begin
      memory_map_enable_d = ipr_wdata_in[xlate_pkg::MAP_ENABLE_BIT];
    end
  end

  always_comb begin
    lookup_d           = '0;
    lookup_d.done      = lookup_valid_in;
    lookup_d.hit       = look_hit;
    lookup_d.miss      = look_miss;
    if (look_hit) begin
      lookup_d.page_table_entry       = hit_pte;
      lookup_d.phys_addr = {hit_pte.page_frame_number, lookup_va_in[xlate_pkg::VA_VPN_LO-1:0]};
    end
  end

  always_comb begin
    ipr_d             = '0;
    ipr_d.rd_ack      = rd_map_enable;
    ipr_d.rd_data     = rd_map_enable ? map_rd_word : 32'h0000_0000;
    ipr_d.rsvd_fault  = rd_write_only;
    ipr_d.probe_done  = xlate_probe;
    ipr_d.psl_ovf_set = probe_hit;
  end

  // Entry storage has no reset; the valid flags alone make it meaningful
  always_ff @(posedge clk_in) begin
    if (xlate_diag_tag) begin
      tag_vpn_q[not_last_used_pointer_q] <= vpn_of(ipr_wdata_in);
    end else if (fill_take) begin
      tag_vpn_q[not_last_used_pointer_q] <= vpn_of(fill_va_in);
    end
    if (xlate_diag_data) begin
      pte_q[not_last_used_pointer_q] <= unpack_pte(ipr_wdata_in);
    end else if (fill_take) begin
      pte_q[not_last_used_pointer_q] <= unpack_pte(fill_pte_in);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      entry_valid_flag_q      <= '0;
      not_last_used_pointer_q <= '0;
      memory_map_enable_q     <= xlate_pkg::MAP_ENABLE_RESET;
      lookup_q                <= '0;
      ipr_q                   <= '0;
    end else begin
      entry_valid_flag_q      <= entry_valid_flag_d;
      not_last_used_pointer_q <= not_last_used_pointer_d;
      memory_map_enable_q     <= memory_map_enable_d;
      lookup_q                <= lookup_d;
      ipr_q                   <= ipr_d;
    end
  end

  assign lookup_out            = lookup_q;
  assign ipr_out               = ipr_q;
  assign memory_map_enable_out = memory_map_enable_q;

endmodule // translation_buffer_nlu

/* File: sim/translation_buffer_nlu_chk.sv */
`timescale 1ns/1ps
module translation_buffer_nlu_chk #(
  parameter int ENTRIES = 64
) (
  input wire logic                 clk_in,
  input wire logic                 rst_n_in,
  input wire logic                 lookup_valid_in,
  input wire logic [31:0]          lookup_va_in,
  input wire logic                 fill_valid_in,
  input wire logic                 ipr_wr_in,
  input wire logic                 ipr_rd_in,
  input wire logic [7:0]           ipr_num_in,
  input wire logic [31:0]          ipr_wdata_in,
  input xlate_pkg::lookup_result_t lookup_out,
  input xlate_pkg::ipr_result_t    ipr_out,
  input wire logic                 memory_map_enable_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic flush = ipr_wr_in && (ipr_num_in inside {[8'h08:8'h0d], 8'h38, 8'h39});
  wire logic rd_wo = ipr_rd_in && (ipr_num_in inside {8'h2f, 8'h39, 8'h3a, 8'h3b, 8'h3f});
  a_lookup_answer: assert property (lookup_valid_in |=> lookup_out.done && (lookup_out.hit ^ lookup_out.miss))
    else $error("lookup not answered");
  a_no_request_quiet: assert property (!lookup_valid_in |=> !lookup_out.done)
    else $error("answer without request");
  a_miss_zeroed: assert property (lookup_out.miss |-> lookup_out.page_table_entry == '0 && lookup_out.phys_addr == '0)
    else $error("miss carries data");
  a_phys_formed: assert property (lookup_out.hit |->
    lookup_out.phys_addr == {lookup_out.page_table_entry.page_frame_number, $past(lookup_va_in[8:0])})
    else $error("bad physical address");
  a_flush_miss: assert property (flush ##1 (!fill_valid_in && !lookup_valid_in) ##1 lookup_valid_in |=> lookup_out.miss)
    else $error("hit after flush");
  a_map_write: assert property (ipr_wr_in && ipr_num_in == 8'h38 |=> memory_map_enable_out == $past(ipr_wdata_in[0]))
    else $error("map enable not stored");
  a_map_read: assert property (ipr_rd_in && ipr_num_in == 8'h38 |=>
    ipr_out.rd_ack && ipr_out.rd_data == {31'h0, $past(memory_map_enable_out)})
    else $error("map enable read wrong");
  a_wo_fault: assert property (rd_wo |=> ipr_out.rsvd_fault && !ipr_out.rd_ack)
    else $error("write-only read not faulted");
  a_probe_done: assert property (ipr_wr_in && ipr_num_in == 8'h3f |=> ipr_out.probe_done)
    else $error("probe not answered");
  a_race_miss: assert property (lookup_valid_in && flush |=> lookup_out.miss && !lookup_out.hit)
    else $error("lookup racing flush hit");
  c_hit: cover property (lookup_out.hit);
  c_miss: cover property (lookup_out.miss);
  c_ovf: cover property (ipr_out.psl_ovf_set);
endmodule // translation_buffer_nlu_chk

bind translation_buffer_nlu translation_buffer_nlu_chk #(.ENTRIES(ENTRIES)) chk (.clk_in, .rst_n_in,
  .lookup_valid_in, .lookup_va_in, .fill_valid_in, .ipr_wr_in, .ipr_rd_in, .ipr_num_in, .ipr_wdata_in,
  .lookup_out, .ipr_out, .memory_map_enable_out);

/* File: sim/xlate_walker_model.sv */
`timescale 1ns/1ps
module xlate_walker_model (
  input  wire logic        clk_in,
  input  wire logic        req_in,
  input  wire logic [31:0] va_in,
  input  wire logic        miss_in,
  input  wire logic [3:0]  lat_in,
  output logic             fill_valid_out,
  output logic [31:0]      fill_va_out,
  output logic [31:0]      fill_pte_out
);
  logic [31:0] va_q = '0;
  logic [4:0]  cnt_q = '0;
  initial fill_valid_out = 1'b0;
  initial fill_va_out = '0;
  initial fill_pte_out = '0;
  always @(posedge clk_in) if (req_in) va_q <= va_in;
  // Idle lines flip each cycle so a stale value never passes for a fresh one
  always @(negedge clk_in) begin
    fill_valid_out <= 1'b0;
    fill_va_out <= ~fill_va_out;
    fill_pte_out <= ~fill_pte_out;
    if (miss_in)
      cnt_q <= {1'b0, lat_in} + 5'h01;
    else if (cnt_q != 5'h00)
      cnt_q <= cnt_q - 5'h01;
    if (cnt_q == 5'h01) begin
      fill_valid_out <= 1'b1;
      fill_va_out <= va_q;
      fill_pte_out <= {1'b1, ~va_q[30:0]};
    end
  end
endmodule // xlate_walker_model

/* File: sim/translation_buffer_nlu_tb_top.sv */
`timescale 1ns/1ps
module translation_buffer_nlu_tb_top;
  logic                      clk = 0, rst_n = 0, lv = 0, wr = 0, rd = 0, fv, men;
  logic [31:0]               va = 0, wd = 0, fva, fpte, a, pd;
  logic [7:0]                num = 0;
  logic [3:0]                lat = 0;
  int                        failures = 0, total_checks = 0;
  logic [7:0]                fl [8] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h38, 8'h39};
  logic [7:0]                wo [5] = '{8'h2f, 8'h39, 8'h3a, 8'h3b, 8'h3f};
  xlate_pkg::lookup_result_t lo;
  xlate_pkg::ipr_result_t    io;
  always #12.5 clk = ~clk;
  translation_buffer_nlu DUT (.clk_in(clk), .rst_n_in(rst_n), .lookup_valid_in(lv), .lookup_va_in(va),
    .fill_valid_in(fv), .fill_va_in(fva), .fill_pte_in(fpte), .ipr_wr_in(wr), .ipr_rd_in(rd),
    .ipr_num_in(num), .ipr_wdata_in(wd), .lookup_out(lo), .ipr_out(io), .memory_map_enable_out(men));
  xlate_walker_model walker (.clk_in(clk), .req_in(lv), .va_in(va), .miss_in(lo.miss), .lat_in(lat),
    .fill_valid_out(fv), .fill_va_out(fva), .fill_pte_out(fpte));
  function automatic logic [31:0] pte_of(input logic [31:0] v);
    return {1'b1, ~v[30:0]};
  endfunction
  // Bit 31 alternates so process and system pages share the array
  function automatic logic [31:0] pg(input logic [5:0] i);
    return {i[0], 16'h0, i, 9'h000};
  endfunction
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic processor_register(input logic w, input logic [7:0] n, input logic [31:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    num = n;
    wd = d;
    @(negedge clk);
    wr = 0;
    rd = 0;
  endtask
  task automatic look(input logic [31:0] v, input logic h, input logic [31:0] p);
    @(negedge clk);
    lv = 1;
    va = v;
    @(negedge clk);
    lv = 0;
    va = ~v;
    chk(lo.hit, h);
    if (h)
      chk({lo.page_table_entry, lo.phys_addr}, {p[31:26], p[20:0], p[20:0], v[8:0]});
    else
      repeat (8) @(negedge clk);
  endtask
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hf30eff80));
    repeat (10) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    processor_register(0, 8'h38, 0);
    chk({io.rd_ack, io.rd_data}, {1'b1, 32'h0});
    processor_register(1, 8'h38, 32'h1);
    processor_register(0, 8'h38, 0);
    chk({io.rd_ack, io.rd_data, men}, {1'b1, 32'h1, 1'b1});
    foreach (wo[i]) begin
      processor_register(0, wo[i], 0);
      chk({io.rsvd_fault, io.rd_ack}, 2'b10);
    end
    repeat (6) begin
      lat = 4'($urandom_range(0, 5));
      a = $urandom;
      look(a, 0, 0);
      look(a, 1, pte_of(a));
      processor_register(1, 8'h3f, a);
      chk({io.probe_done, io.psl_ovf_set}, 2'b11);
    end
    foreach (fl[i]) begin
      processor_register(1, fl[i], $urandom | 32'h1);
      look(a, 0, 0);
      look(a, 1, pte_of(a));
    end
    chk(men, 1'b1);
    pd = a ^ 32'h200;
    look(pd, 0, 0);
    processor_register(1, 8'h3a, a);
    look(pd, 1, pte_of(pd));
    processor_register(1, 8'h3f, a);
    chk(io.psl_ovf_set, 1'b0);
    look(a, 0, 0);
    processor_register(1, 8'h39, 0);
    a = $urandom;
    pd = $urandom | 32'h8000_0000;
    processor_register(1, 8'h2f, a);
    processor_register(1, 8'h3b, pd);
    look(a, 1, pd);
    // Lookup in the same cycle as a flush must miss even though the page is held
    @(negedge clk);
    lv = 1;
    va = a;
    wr = 1;
    num = 8'h39;
    @(negedge clk);
    lv = 0;
    wr = 0;
    chk(lo.miss, 1'b1);
    repeat (8) @(negedge clk);
    processor_register(1, 8'h39, 0);
    lat = 0;
    for (int i = 0; i < 64; i++) look(pg(6'(i)), 0, 0);
    for (int i = 0; i < 64; i++) look(pg(6'(i)), 1, pte_of(pg(6'(i))));
    look(pg(0), 1, pte_of(pg(0)));
    look(32'h0040_0000, 0, 0);
    look(pg(0), 1, pte_of(pg(0)));
    look(pg(1), 0, 0);
    results();
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    results();
  end
endmodule // translation_buffer_nlu_tb_top
